/* rtl/rtb_sync2.v */
`timescale 1ns/10ps
// ----------------------------------------
// two-flop synchroniser
// ----------------------------------------
module rtb_sync2 (
    input wire clock,
    input wire arst_n,
    input wire d,
    output reg q
);
reg meta_r;
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        meta_r <= 1'b0;
        q <= 1'b0;
    end else begin
        meta_r <= d;
        q <= meta_r;
    end
end
endmodule // rtb_sync2

/* rtl/rtb_trigger_bank.v */
`timescale 1ns/10ps
`include "rtb_trigger_bank_regs.vh"
module rtb_trigger_bank #(
    parameter [3:0] USID = `RTB_SID_DEFAULT
) (
    input wire clock,
    input wire rst_n,
    input wire interface_supply,
    input wire serial_clock,
    input wire serial_data_line_i,
    output reg serial_data_line_o,
    output reg serial_data_line_oe,
    output reg [7:0] voltage_code,
    output reg mode_low_power,
    output reg mode_standby,
    output reg mode_active,
    output reg mode_forced_bypass,
    output reg pulse_skip_operation_en,
    output reg forced_bypass_select,
    output reg output_pin_o,
    output reg output_pin_oe
);
// ----------------------------------------
// reset and input sampling
// ----------------------------------------
localparam S_IDLE = 5'h01;
localparam S_CMD = 5'h02;
localparam S_DATA = 5'h04;
localparam S_TURN = 5'h08;
localparam S_RDATA = 5'h10;
wire arst_n = rst_n & interface_supply;
wire sclk_s;
wire serial_data_line_s;
reg sclk_d;
reg serial_data_line_d;
rtb_sync2 u_sync_clk (
    .clock(clock),
    .arst_n(arst_n),
    .d(serial_clock),
    .q(sclk_s)
);
rtb_sync2 u_sync_dat (
    .clock(clock),
    .arst_n(arst_n),
    .d(serial_data_line_i),
    .q(serial_data_line_s)
);
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        sclk_d <= 1'b0;
        serial_data_line_d <= 1'b0;
    end else begin
        sclk_d <= sclk_s;
        serial_data_line_d <= serial_data_line_s;
    end
end
wire sclk_rise = sclk_s & ~sclk_d;
wire sclk_fall = sclk_d & ~sclk_s;
wire serial_data_line_rise = serial_data_line_s & ~serial_data_line_d;
wire serial_data_line_fall = serial_data_line_d & ~serial_data_line_s;
// ----------------------------------------
// register storage
// ----------------------------------------
reg [7:0] code_pend_r;
reg auto_act_r;
reg auto_pend_r;
reg byp_act_r;
reg byp_pend_r;
reg lvl_act_r;
reg lvl_pend_r;
reg pen_act_r;
reg pen_pend_r;
reg [2:0] mask_r;
// ----------------------------------------
// serial frame engine
// ----------------------------------------
reg [4:0] state_r;
reg [3:0] cnt_r;
reg [11:0] shift_r;
reg [7:0] dshift_r;
reg [8:0] rd_shift_r;
reg [4:0] addr_r;
reg arm_r;
wire [12:0] cmd_full = {shift_r, serial_data_line_s};
wire [3:0] cmd_sid = shift_r[11:8];
wire [2:0] cmd_op = shift_r[7:5];
wire [4:0] cmd_addr = shift_r[4:0];
wire cmd_par_ok = ^cmd_full;
wire sid_own = (cmd_sid == USID);
wire sid_hit = sid_own | (cmd_sid == `RTB_SID_BCAST);
wire dat_par_ok = ^{dshift_r, serial_data_line_s};
wire wr_stb = (state_r == S_DATA) & sclk_fall & (cnt_r == `RTB_DATA_LAST) & dat_par_ok;
reg [7:0] rd_val;
always @* begin
    rd_val = 8'h00;
    case (cmd_addr)
        `RTB_ADDR_COARSE: begin
            rd_val = {1'b0, voltage_code[7:1]};
        end
        `RTB_ADDR_FINE: begin
            rd_val = voltage_code;
        end
        `RTB_ADDR_CFG: begin
            rd_val[`RTB_CFG_AUTO_BIT] = auto_act_r;
            rd_val[`RTB_CFG_BYP_BIT] = byp_act_r;
        end
        `RTB_ADDR_PIN: begin
            rd_val[`RTB_PIN_LVL_BIT] = lvl_act_r;
            rd_val[`RTB_PIN_EN_BIT] = pen_act_r;
        end
        `RTB_ADDR_TRIG: begin
            rd_val[`RTB_MASK_MSB:`RTB_MASK_LSB] = mask_r;
        end
        default: begin
            rd_val = 8'h00;
        end
    endcase
end
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        state_r <= S_IDLE;
        cnt_r <= 4'h0;
        shift_r <= 12'h000;
        dshift_r <= 8'h00;
        rd_shift_r <= 9'h000;
        addr_r <= 5'h00;
        arm_r <= 1'b0;
        serial_data_line_o <= 1'b0;
        serial_data_line_oe <= 1'b0;
    end else if (!sclk_s && !serial_data_line_oe && arm_r && serial_data_line_fall) begin
        state_r <= S_CMD;
        cnt_r <= 4'h0;
        arm_r <= 1'b0;
    end else begin
        if (sclk_rise) begin
            arm_r <= 1'b0;
        end else if (!sclk_s && !serial_data_line_oe && serial_data_line_rise) begin
            arm_r <= 1'b1;
        end
        case (state_r)
            S_IDLE: begin
                cnt_r <= 4'h0;
            end
            S_CMD: begin
                if (sclk_fall) begin
                    shift_r <= cmd_full[11:0];
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `RTB_CMD_LAST) begin
                        cnt_r <= 4'h0;
                        addr_r <= cmd_addr;
                        rd_shift_r <= {rd_val, ~^rd_val};
                        if (cmd_par_ok && sid_hit && cmd_op == `RTB_CMD_WRITE) begin
                            state_r <= S_DATA;
                        end else if (cmd_par_ok && sid_own && cmd_op == `RTB_CMD_READ) begin
                            state_r <= S_TURN;
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                end
            end
            S_DATA: begin
                if (sclk_fall) begin
                    dshift_r <= {dshift_r[6:0], serial_data_line_s};
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `RTB_DATA_LAST) begin
                        state_r <= S_IDLE;
                    end
                end
            end
            S_TURN: begin
                if (sclk_fall) begin
                    state_r <= S_RDATA;
                end
            end
            S_RDATA: begin
                if (sclk_rise) begin
                    serial_data_line_oe <= 1'b1;
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `RTB_RD_PARK) begin
                        serial_data_line_o <= 1'b0;
                    end else begin
                        serial_data_line_o <= rd_shift_r[8];
                        rd_shift_r <= {rd_shift_r[7:0], 1'b0};
                    end
                end else if (sclk_fall && cnt_r > `RTB_RD_PARK) begin
                    serial_data_line_oe <= 1'b0;
                    state_r <= S_IDLE;
                end
            end
            default: begin
                state_r <= S_IDLE;
            end
        endcase
    end
end
// ----------------------------------------
// write and trigger handling
// ----------------------------------------
wire [7:0] wd = dshift_r;
wire trig_off = &mask_r;
wire trig_hit = wr_stb & (addr_r == `RTB_ADDR_TRIG) &
    (|(wd[`RTB_TRIG_MSB:`RTB_TRIG_LSB] & ~wd[`RTB_MASK_MSB:`RTB_MASK_LSB]));
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        code_pend_r <= `RTB_RST_CODE;
        voltage_code <= `RTB_RST_CODE;
        auto_pend_r <= `RTB_RST_BIT;
        auto_act_r <= `RTB_RST_BIT;
        byp_pend_r <= `RTB_RST_BIT;
        byp_act_r <= `RTB_RST_BIT;
        lvl_pend_r <= `RTB_RST_BIT;
        lvl_act_r <= `RTB_RST_BIT;
        pen_pend_r <= `RTB_RST_BIT;
        pen_act_r <= `RTB_RST_BIT;
        mask_r <= `RTB_RST_MASK;
    end else if (trig_hit) begin
        mask_r <= wd[`RTB_MASK_MSB:`RTB_MASK_LSB];
        voltage_code <= code_pend_r;
        auto_act_r <= auto_pend_r;
        byp_act_r <= byp_pend_r;
        lvl_act_r <= lvl_pend_r;
        pen_act_r <= pen_pend_r;
    end else if (wr_stb) begin
        case (addr_r)
            `RTB_ADDR_COARSE: begin
                code_pend_r <= {wd[`RTB_COARSE_MSB:0], 1'b0};
                if (trig_off) begin
                    voltage_code <= {wd[`RTB_COARSE_MSB:0], 1'b0};
                end
            end
            `RTB_ADDR_FINE: begin
                code_pend_r <= wd;
                if (trig_off) begin
                    voltage_code <= wd;
                end
            end
            `RTB_ADDR_CFG: begin
                auto_pend_r <= wd[`RTB_CFG_AUTO_BIT];
                byp_pend_r <= wd[`RTB_CFG_BYP_BIT];
                if (trig_off) begin
                    auto_act_r <= wd[`RTB_CFG_AUTO_BIT];
                    byp_act_r <= wd[`RTB_CFG_BYP_BIT];
                end
            end
            `RTB_ADDR_PIN: begin
                lvl_pend_r <= wd[`RTB_PIN_LVL_BIT];
                pen_pend_r <= wd[`RTB_PIN_EN_BIT];
                if (trig_off) begin
                    lvl_act_r <= wd[`RTB_PIN_LVL_BIT];
                    pen_act_r <= wd[`RTB_PIN_EN_BIT];
                end
            end
            `RTB_ADDR_TRIG: begin
                mask_r <= wd[`RTB_MASK_MSB:`RTB_MASK_LSB];
            end
            default: begin
                mask_r <= mask_r;
            end
        endcase
    end
end
// ----------------------------------------
// mode decode outputs
// ----------------------------------------
wire [6:0] coarse = voltage_code[7:1];
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        mode_low_power <= 1'b0;
        mode_standby <= 1'b0;
        mode_active <= 1'b0;
        mode_forced_bypass <= 1'b0;
        pulse_skip_operation_en <= 1'b0;
        forced_bypass_select <= 1'b0;
        output_pin_o <= 1'b0;
        output_pin_oe <= 1'b0;
    end else begin
        mode_low_power <= (coarse == `RTB_CODE_LOW_POWER);
        mode_standby <= (coarse == `RTB_CODE_STANDBY);
        mode_active <= (coarse >= `RTB_CODE_ACTIVE_MIN) && (coarse != `RTB_CODE_BYPASS);
        mode_forced_bypass <= (coarse == `RTB_CODE_BYPASS);
        pulse_skip_operation_en <= auto_act_r;
        forced_bypass_select <= byp_act_r;
        output_pin_o <= lvl_act_r;
        output_pin_oe <= pen_act_r;
    end
end
endmodule // rtb_trigger_bank

/* shared/rtb_trigger_bank_regs.vh */
`ifndef RTB_TRIGGER_BANK_REGS_VH
`define RTB_TRIGGER_BANK_REGS_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define RTB_ADDR_COARSE 5'h00
`define RTB_ADDR_CFG 5'h01
`define RTB_ADDR_PIN 5'h02
`define RTB_ADDR_FINE 5'h03
`define RTB_ADDR_TRIG 5'h1C
// ----------------------------------------
// field positions
// ----------------------------------------
`define RTB_CFG_AUTO_BIT 5
`define RTB_CFG_BYP_BIT 4
`define RTB_PIN_LVL_BIT 7
`define RTB_PIN_EN_BIT 6
`define RTB_TRIG_MSB 2
`define RTB_TRIG_LSB 0
`define RTB_MASK_MSB 5
`define RTB_MASK_LSB 3
`define RTB_COARSE_MSB 6
// ----------------------------------------
// reset values
// ----------------------------------------
`define RTB_RST_CODE 8'h00
`define RTB_RST_BIT 1'h0
`define RTB_RST_MASK 3'h0
// ----------------------------------------
// coarse code decode
// ----------------------------------------
`define RTB_CODE_LOW_POWER 7'h00
`define RTB_CODE_STANDBY 7'h02
`define RTB_CODE_ACTIVE_MIN 7'h03
`define RTB_CODE_BYPASS 7'h7F
// ----------------------------------------
// serial framing
// ----------------------------------------
`define RTB_CMD_WRITE 3'h2
`define RTB_CMD_READ 3'h3
`define RTB_SID_BCAST 4'h0
`define RTB_SID_DEFAULT 4'h4
`define RTB_CMD_LAST 4'hC
`define RTB_DATA_LAST 4'h8
`define RTB_RD_PARK 4'h9
`endif

/* tb/rtb_bus_master.sv */
`timescale 1ns/10ps
`include "rtb_trigger_bank_regs.vh"
module rtb_bus_master (
    input wire logic clock,
    output logic serial_clock,
    output logic serial_data_line_i,
    input wire logic serial_data_line_o,
    input wire logic serial_data_line_oe
);
    logic m_en = 1'b1;
    logic m_d = 1'b0;
    initial serial_clock = 1'b0;
    // released wire shows inverse of last master level
    assign serial_data_line_i = serial_data_line_oe ? serial_data_line_o : (m_en ? m_d : ~m_d);
    // launch on rise, far side samples on fall
    task automatic cyc(input logic b, input logic en);
        serial_clock = 1'b1;
        m_en = en;
        m_d = en ? b : m_d;
        #100 serial_clock = 1'b0;
        #100;
    endtask
    task automatic frame(input logic [4:0] a, input logic [2:0] op);
        logic [11:0] c;
        c = {`RTB_SID_DEFAULT, op, a};
        @(posedge clock);
        #5 m_d = 1'b1;
        #100 m_d = 1'b0;
        #100;
        for (int i = 11; i >= 0; i--) cyc(c[i], 1'b1);
        cyc(~^c, 1'b1);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        frame(a, `RTB_CMD_WRITE);
        for (int i = 7; i >= 0; i--) cyc(d[i], 1'b1);
        cyc(~^d, 1'b1);
        cyc(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        frame(a, `RTB_CMD_READ);
        cyc(1'b0, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            serial_clock = 1'b1;
            #100 d[i] = serial_data_line_i;
            serial_clock = 1'b0;
            #100;
        end
        cyc(1'b0, 1'b0);
        cyc(1'b0, 1'b0);
        m_en = 1'b1;
        m_d = 1'b0;
    endtask
endmodule // rtb_bus_master

/* tb/rtb_trigger_bank_checker.sv */
`timescale 1ns/10ps
module rtb_trigger_bank_checker (
    input wire clock,
    input wire rst_n,
    input wire interface_supply,
    input wire serial_clock,
    input wire serial_data_line_o,
    input wire serial_data_line_oe,
    input wire [7:0] voltage_code,
    input wire mode_low_power,
    input wire mode_standby,
    input wire mode_active,
    input wire mode_forced_bypass
);
    wire [3:0] modes = {mode_low_power, mode_standby, mode_active, mode_forced_bypass};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n || !interface_supply);
    chk_lp_decode: assert property (mode_low_power |-> $past(voltage_code[7:1]) == 7'h00)
        else $error("low-power mode on wrong code");
    chk_sb_decode: assert property (mode_standby |-> $past(voltage_code[7:1]) == 7'h02)
        else $error("standby mode on wrong code");
    chk_act_decode: assert property (
        mode_active |-> $past(voltage_code[7:1]) inside {[7'h03:7'h7E]})
        else $error("active mode on wrong code");
    chk_byp_decode: assert property (
        mode_forced_bypass |-> $past(voltage_code[7:1]) == 7'h7F)
        else $error("bypass mode on wrong code");
    chk_mode_follow: assert property (
        $changed(voltage_code) && voltage_code[7:1] != 7'h01 |=> $onehot(modes))
        else $error("no mode after code change");
    chk_sdo_launch: assert property ($changed(serial_data_line_o) |-> $past(serial_clock))
        else $error("data launched off clock high phase");
    chk_oe_rise: assert property ($rose(serial_data_line_oe) |-> $past(serial_clock))
        else $error("drive started off clock high phase");
    chk_oe_fall: assert property ($fell(serial_data_line_oe) |-> !$past(serial_clock))
        else $error("drive released off clock low phase");
    chk_supply_clear: assert property (@(posedge clock) disable iff (!rst_n)
        !interface_supply |-> voltage_code == 8'h00 && modes == 4'h0 && !serial_data_line_oe)
        else $error("state kept without supply");
endmodule // rtb_trigger_bank_checker

/* tb/rtb_trigger_bank_tb_top.sv */
`timescale 1ns/10ps
`include "rtb_trigger_bank_regs.vh"
module rtb_trigger_bank_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic interface_supply = 1'b1;
    logic serial_clock, serial_data_line_i, serial_data_line_o, serial_data_line_oe;
    logic [7:0] voltage_code;
    logic mode_low_power, mode_standby, mode_active, mode_forced_bypass;
    logic pulse_skip_operation_en, forced_bypass_select, output_pin_o, output_pin_oe;
    logic [7:0] rv;
    int n_errors = 0;
    int tests_run = 0;
    wire [3:0] outs = {pulse_skip_operation_en, forced_bypass_select, output_pin_o, output_pin_oe};
    wire [3:0] modes = {mode_low_power, mode_standby, mode_active, mode_forced_bypass};
    logic [6:0] cd [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h0D, 7'h78, 7'h7E, 7'h7F};
    logic [3:0] md [8] = '{4'h8, 4'h0, 4'h4, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1};
    always #12.5 clock = ~clock;
    rtb_trigger_bank u_rtb_trigger_bank (.clock, .rst_n, .interface_supply, .serial_clock,
        .serial_data_line_i, .serial_data_line_o, .serial_data_line_oe, .voltage_code,
        .mode_low_power, .mode_standby, .mode_active, .mode_forced_bypass,
        .pulse_skip_operation_en, .forced_bypass_select, .output_pin_o, .output_pin_oe);
    rtb_bus_master u_rtb_bus_master (.clock, .serial_clock, .serial_data_line_i,
        .serial_data_line_o, .serial_data_line_oe);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_reset;
        chk({voltage_code[3:0], outs}, 8'h00);
        for (int a = 0; a < 3; a++) begin
            u_rtb_bus_master.rd(a[4:0], rv);
            chk(rv, 8'h00);
        end
        $display("t_reset done");
    endtask
    task automatic t_pending;
        u_rtb_bus_master.wr(`RTB_ADDR_CFG, 8'h30);
        chk(outs, 4'h0);
        u_rtb_bus_master.rd(`RTB_ADDR_CFG, rv);
        chk(rv, 8'h00);
        u_rtb_bus_master.wr(`RTB_ADDR_TRIG, 8'h01);
        chk(outs, 4'hC);
        for (int i = 0; i < 3; i++) begin
            u_rtb_bus_master.wr(`RTB_ADDR_CFG, i[0] ? 8'h20 : 8'h10);
            chk(outs[3:2], (i == 0) ? 2'h3 : (i[0] ? 2'h1 : 2'h2));
            u_rtb_bus_master.wr(`RTB_ADDR_TRIG, 8'h01 << i);
            chk(outs[3:2], i[0] ? 2'h2 : 2'h1);
        end
        $display("t_pending done");
    endtask
    task automatic t_masked;
        u_rtb_bus_master.wr(`RTB_ADDR_CFG, 8'h30);
        u_rtb_bus_master.wr(`RTB_ADDR_TRIG, 8'h09);
        chk(outs[3:2], 2'h1);
        u_rtb_bus_master.wr(`RTB_ADDR_TRIG, 8'h0A);
        chk(outs[3:2], 2'h3);
        $display("t_masked done");
    endtask
    task automatic t_direct;
        u_rtb_bus_master.wr(`RTB_ADDR_TRIG, 8'h38);
        u_rtb_bus_master.wr(`RTB_ADDR_CFG, 8'h00);
        chk(outs[3:2], 2'h0);
        u_rtb_bus_master.wr(`RTB_ADDR_PIN, 8'hC0);
        chk(outs[1:0], 2'h3);
        for (int i = 0; i < 8; i++) begin
            u_rtb_bus_master.wr(`RTB_ADDR_COARSE, {1'b1, cd[i]});
            chk(voltage_code, {cd[i], 1'b0});
            chk(modes, md[i]);
            u_rtb_bus_master.rd(`RTB_ADDR_COARSE, rv);
            chk(rv, {1'b0, cd[i]});
        end
        u_rtb_bus_master.wr(`RTB_ADDR_FINE, 8'h1B);
        chk(voltage_code, 8'h1B);
        u_rtb_bus_master.rd(`RTB_ADDR_COARSE, rv);
        chk(rv, 8'h0D);
        $display("t_direct done");
    endtask
    task automatic t_reserved;
        u_rtb_bus_master.wr(`RTB_ADDR_CFG, 8'hFF);
        u_rtb_bus_master.rd(`RTB_ADDR_CFG, rv);
        chk(rv, 8'h30);
        u_rtb_bus_master.wr(5'h05, 8'hA5);
        u_rtb_bus_master.rd(5'h05, rv);
        chk(rv, 8'h00);
        u_rtb_bus_master.rd(`RTB_ADDR_TRIG, rv);
        chk(rv, 8'h38);
        $display("t_reserved done");
    endtask
    task automatic t_supply;
        @(posedge clock);
        interface_supply <= 1'b0;
        repeat (2) @(posedge clock);
        chk({voltage_code[3:0], outs}, 8'h00);
        interface_supply <= 1'b1;
        repeat (4) @(posedge clock);
        u_rtb_bus_master.wr(`RTB_ADDR_CFG, 8'h10);
        chk(outs, 4'h0);
        $display("t_supply done");
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset;
        t_pending;
        t_masked;
        t_direct;
        t_reserved;
        t_supply;
        results;
    end
    initial begin
        #1000000;
        n_errors++;
        results;
    end
endmodule // rtb_trigger_bank_tb_top
bind rtb_trigger_bank rtb_trigger_bank_checker u_rtb_trigger_bank_checker (.clock, .rst_n,
    .interface_supply, .serial_clock, .serial_data_line_o, .serial_data_line_oe,
    .voltage_code, .mode_low_power, .mode_standby, .mode_active, .mode_forced_bypass);
